// >>> iqcfg_pkg.sv
// Package for the IQ sample port configuration block.
// Assumes a 32-bit Avalon-MM slave with word addressing by byte offsets.
package iqcfg_pkg;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h04;
  localparam logic [7:0] REG_PORT = 8'h08;
  localparam logic [7:0] REG_MAP_OUT = 8'h0c;
  localparam logic [7:0] REG_MAP_IN = 8'h10;
  localparam logic [7:0] REG_CLKSEL = 8'h14;
  localparam logic [7:0] REG_PAD = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1c;
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_001f;
  localparam logic [31:0] RESET_RST = 32'h0000_0000;
  localparam logic [31:0] PORT_RST = 32'h0000_1130;
  localparam logic [31:0] MAP_RST = 32'h0000_e4e4;
  localparam logic [31:0] CLKSEL_RST = 32'h0000_0010;
  localparam logic [31:0] PAD_RST = 32'h0003_ffff;
  localparam logic [31:0] WAIT_DEF = 32'h0000_0001;
  // Field masks
  localparam logic [31:0] CTRL_MASK = 32'h0000_001f;
  localparam logic [31:0] RESET_MASK = 32'h0000_03ff;
  localparam logic [31:0] PORT_MASK = 32'h0000_ffff;
  localparam logic [31:0] MAP_MASK = 32'h0000_ffff;
  localparam logic [31:0] CLKSEL_MASK = 32'h0000_00ff;
  localparam logic [31:0] PAD_MASK = 32'h007f_ffff;
  // Bit positions
  localparam int CTRL_IF_EN = 4;
  localparam int RST_RXFIFO = 8;
  localparam int RST_TXFIFO = 9;
  localparam int PORT_FS = 0;
  localparam int PORT_JESD = 4;
  localparam int PORT_RXDIR = 8;
  localparam int PORT_WAIT = 12;
  // Encodings
  localparam logic [1:0] SRC_RXPROC = 2'h0;
  localparam logic [1:0] SRC_LOOP = 2'h1;
  localparam logic [1:0] SRC_LFSR = 2'h2;
  localparam logic [15:0] LFSR_SEED = 16'hace1;
  localparam logic [15:0] LFSR_TAPS = 16'hb400;
  typedef struct packed {
    logic [15:0] ai;
    logic [15:0] aq;
    logic [15:0] bi;
    logic [15:0] bq;
  } iqcfg_samples_t;
endpackage

// >>> iqcfg_top.sv
// IQ sample port configuration and per-port framing for two parallel ports.
// Assumes fast clocks and frame-sync pins are asynchronous; synced here.
`timescale 1ns/1ns
module iqcfg_top #(
  parameter int DATA_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Port link pins (level inputs, sampled)
  input wire logic fast_clock_in_1,
  input wire logic fast_clock_in_2,
  input wire logic [1:0] frame_sync_in,
  input wire logic [2*DATA_W-1:0] sample_bus_in,
  output logic [2*DATA_W-1:0] sample_bus_out,
  output logic [1:0] sample_bus_oe,
  output logic [1:0] frame_sync_out,
  // Sample streams
  input iqcfg_pkg::iqcfg_samples_t rx_proc_samples,
  output iqcfg_pkg::iqcfg_samples_t tx_samples,
  output logic tx_samples_valid,
  output iqcfg_pkg::iqcfg_samples_t rx_fifo_samples,
  // Configuration outputs
  output logic [3:0] chan_enable,
  output logic [3:0] chan_logic_reset,
  output logic [1:0] tx_read_clk_sel,
  output logic [1:0] tx_write_clk_sel,
  output logic [1:0] rx_read_clk_sel,
  output logic [17:0] pad_pullup,
  output logic [4:0] pad_drive_high
);
  initial begin
    if (DATA_W < 1 || DATA_W > 16) $error("DATA_W out of range");
  end

  logic [31:0] ctrl_q, reset_q, port_q, map_out_q, map_in_q, clksel_q, pad_q;
  logic [31:0] rdata_q;
  logic ack_q;
  logic [3:0] cfgmem_rst;

  // Byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] be, input logic [31:0] msk);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[8*i +: 8] = wd[8*i +: 8];
    end
    return r & msk;
  endfunction

  // Pick a sample by 2-bit code
  function automatic logic [15:0] pick(input iqcfg_pkg::iqcfg_samples_t s,
                                       input logic [1:0] code);
    case (code)
      2'h0: pick = s.ai;
      2'h1: pick = s.aq;
      2'h2: pick = s.bi;
      default: pick = s.bq;
    endcase
  endfunction

  // A write lands only at the edge where waitrequest is low,
  // so the first (wait) cycle of a request never changes state
  wire wr_en = avs_write & ack_q;
  assign cfgmem_rst = reset_q[7:4];

  // One wait state, then ack
  // Ack lasts one cycle; a held request after it starts a new transfer
  // Read data is registered in the wait cycle and stands in the ack cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ack_q <= 1'b0;
    else ack_q <= (avs_read | avs_write) & ~ack_q;
  end
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;

  // Control register: channel and interface enables
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ctrl_q <= iqcfg_pkg::CTRL_RST;
    else if (wr_en && avs_address == iqcfg_pkg::REG_CTRL)
      ctrl_q <= merge(ctrl_q, avs_writedata, avs_byteenable, iqcfg_pkg::CTRL_MASK);
  end

  // Reset controls, all inactive by default
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) reset_q <= iqcfg_pkg::RESET_RST;
    else if (wr_en && avs_address == iqcfg_pkg::REG_RESET)
      reset_q <= merge(reset_q, avs_writedata, avs_byteenable, iqcfg_pkg::RESET_MASK);
  end

  // Port modes; config memory reset restores defaults
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) port_q <= iqcfg_pkg::PORT_RST;
    else if (|cfgmem_rst) port_q <= iqcfg_pkg::PORT_RST;
    else if (wr_en && avs_address == iqcfg_pkg::REG_PORT)
      port_q <= merge(port_q, avs_writedata, avs_byteenable, iqcfg_pkg::PORT_MASK);
  end

  // Slot maps
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      map_out_q <= iqcfg_pkg::MAP_RST;
      map_in_q <= iqcfg_pkg::MAP_RST;
    end else if (|cfgmem_rst) begin
      map_out_q <= iqcfg_pkg::MAP_RST;
      map_in_q <= iqcfg_pkg::MAP_RST;
    end else if (wr_en && avs_address == iqcfg_pkg::REG_MAP_OUT) begin
      map_out_q <= merge(map_out_q, avs_writedata, avs_byteenable, iqcfg_pkg::MAP_MASK);
    end else if (wr_en && avs_address == iqcfg_pkg::REG_MAP_IN) begin
      map_in_q <= merge(map_in_q, avs_writedata, avs_byteenable, iqcfg_pkg::MAP_MASK);
    end
  end

  // Clock selects and data source
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) clksel_q <= iqcfg_pkg::CLKSEL_RST;
    else if (wr_en && avs_address == iqcfg_pkg::REG_CLKSEL)
      clksel_q <= merge(clksel_q, avs_writedata, avs_byteenable, iqcfg_pkg::CLKSEL_MASK);
  end

  // Pad pull-ups and drive strengths
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) pad_q <= iqcfg_pkg::PAD_RST;
    else if (wr_en && avs_address == iqcfg_pkg::REG_PAD)
      pad_q <= merge(pad_q, avs_writedata, avs_byteenable, iqcfg_pkg::PAD_MASK);
  end

  assign chan_enable = ctrl_q[3:0];
  assign chan_logic_reset = reset_q[3:0];
  assign tx_read_clk_sel = clksel_q[1:0];
  assign tx_write_clk_sel = clksel_q[3:2];
  assign rx_read_clk_sel = clksel_q[5:4];
  assign pad_pullup = pad_q[17:0];
  assign pad_drive_high = pad_q[22:18];

  // Link sync: two flops before use
  // Data, frame sync and clocks share the same depth, so a detected
  // fast clock edge lines up with the word that was set up before it
  logic [1:0] fck1_s, fck2_s;
  logic [1:0] fs_s0, fs_s1;
  logic [2*DATA_W-1:0] bus_s0, bus_s1;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fck1_s <= 2'h0;
      fck2_s <= 2'h0;
      fs_s0 <= 2'h0;
      fs_s1 <= 2'h0;
      bus_s0 <= '0;
      bus_s1 <= '0;
    end else begin
      fck1_s <= {fck1_s[0], fast_clock_in_1};
      fck2_s <= {fck2_s[0], fast_clock_in_2};
      fs_s0 <= frame_sync_in;
      fs_s1 <= fs_s0;
      bus_s0 <= sample_bus_in;
      bus_s1 <= bus_s0;
    end
  end

  // Edge detection on the synced fast clocks
  logic fck1_d, fck2_d;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fck1_d <= 1'b0;
      fck2_d <= 1'b0;
    end else begin
      fck1_d <= fck1_s[1];
      fck2_d <= fck2_s[1];
    end
  end
  wire [1:0] fck_rise = {fck2_s[1] & ~fck2_d, fck1_s[1] & ~fck1_d};

  // Incoming frame capture: port in transmit direction
  iqcfg_pkg::iqcfg_samples_t tx_q;
  logic tx_v_q;
  logic [15:0] slot_q [4];
  logic [1:0] in_slot_q;
  logic in_port;
  logic [15:0] in_word;
  logic in_start;
  logic [1:0] in_next;
  logic [15:0] in_cur [4];
  // Slot of the arriving word, and the frame as it stands with that word in
  // The last word is merged here so any slot may feed any sample
  always_comb begin
    in_port = port_q[iqcfg_pkg::PORT_RXDIR] ? 1'b1 : 1'b0;
    in_word = 16'(bus_s1[(in_port ? DATA_W : 0) +: DATA_W]);
    in_start = fs_s1[in_port] == port_q[iqcfg_pkg::PORT_FS + in_port];
    in_next = in_start ? 2'h0 : in_slot_q + 2'h1;
    for (int i = 0; i < 4; i++) in_cur[i] = slot_q[i];
    in_cur[in_next] = in_word;
  end
  wire in_en = ctrl_q[iqcfg_pkg::CTRL_IF_EN] & ~reset_q[iqcfg_pkg::RST_TXFIFO];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_slot_q <= 2'h0;
      tx_q <= '0;
      tx_v_q <= 1'b0;
      for (int i = 0; i < 4; i++) slot_q[i] <= 16'h0000;
    end else if (reset_q[iqcfg_pkg::RST_TXFIFO] || reset_q[3:2] != 2'h0) begin
      in_slot_q <= 2'h0;
      tx_v_q <= 1'b0;
      tx_q <= '0;
    end else begin
      tx_v_q <= 1'b0;
      if (in_en && fck_rise[in_port]) begin
        slot_q[in_next] <= in_word;
        in_slot_q <= in_next;
        if (in_next == 2'h3) begin
          tx_q.ai <= ctrl_q[2] ? in_cur[map_in_q[1:0]] : 16'h0000;
          tx_q.aq <= ctrl_q[2] ? in_cur[map_in_q[3:2]] : 16'h0000;
          tx_q.bi <= ctrl_q[3] ? in_cur[map_in_q[5:4]] : 16'h0000;
          tx_q.bq <= ctrl_q[3] ? in_cur[map_in_q[7:6]] : 16'h0000;
          tx_v_q <= 1'b1;
        end
      end
    end
  end
  assign tx_samples = tx_q;
  assign tx_samples_valid = tx_v_q;

  // Receive FIFO source with LFSR
  // The generator restarts from its seed on any receive-side reset,
  // so a test pattern is repeatable after a soft reset
  logic [15:0] lfsr_q;
  iqcfg_pkg::iqcfg_samples_t rxsrc_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lfsr_q <= iqcfg_pkg::LFSR_SEED;
      rxsrc_q <= '0;
    end else if (reset_q[iqcfg_pkg::RST_RXFIFO] || reset_q[1:0] != 2'h0) begin
      lfsr_q <= iqcfg_pkg::LFSR_SEED;
      rxsrc_q <= '0;
    end else begin
      lfsr_q <= {lfsr_q[14:0], ^(lfsr_q & iqcfg_pkg::LFSR_TAPS)};
      case (clksel_q[7:6])
        iqcfg_pkg::SRC_RXPROC: rxsrc_q <= rx_proc_samples;
        iqcfg_pkg::SRC_LOOP: rxsrc_q <= tx_q;
        iqcfg_pkg::SRC_LFSR: rxsrc_q <= {4{lfsr_q}};
        default: rxsrc_q <= rx_proc_samples;
      endcase
      if (!ctrl_q[0]) begin
        rxsrc_q.ai <= 16'h0000;
        rxsrc_q.aq <= 16'h0000;
      end
      if (!ctrl_q[1]) begin
        rxsrc_q.bi <= 16'h0000;
        rxsrc_q.bq <= 16'h0000;
      end
    end
  end
  assign rx_fifo_samples = rxsrc_q;

  // Outgoing frame drive with JESD207 start/stop wait
  // Drive changes only on fast clock edges, except that an RX FIFO reset clears the enables at once;
  // with the link clock stopped the enable holds its last state until clocks run again or that reset
  logic [1:0] out_slot_q;
  logic [2*DATA_W-1:0] out_q;
  logic [1:0] oe_q, fso_q;
  logic [3:0] wait_q;
  logic out_port;
  assign out_port = port_q[iqcfg_pkg::PORT_RXDIR + 1] ? 1'b1 : 1'b0;
  wire out_on = ctrl_q[iqcfg_pkg::CTRL_IF_EN] & ~reset_q[iqcfg_pkg::RST_RXFIFO];
  wire jesd = port_q[iqcfg_pkg::PORT_JESD + out_port];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_slot_q <= 2'h0;
      out_q <= '0;
      oe_q <= 2'h0;
      fso_q <= 2'h0;
      wait_q <= 4'h0;
    end else if (reset_q[iqcfg_pkg::RST_RXFIFO]) begin
      out_slot_q <= 2'h0;
      oe_q <= 2'h0;
      wait_q <= 4'h0;
    end else if (fck_rise[out_port]) begin
      if (jesd && oe_q[out_port] != out_on && wait_q < port_q[iqcfg_pkg::PORT_WAIT +: 4]) begin
        wait_q <= wait_q + 4'h1;
      end else begin
        wait_q <= 4'h0;
        oe_q <= 2'h0;
        oe_q[out_port] <= out_on;
      end
      out_slot_q <= out_slot_q + 2'h1;
      out_q[(out_port ? DATA_W : 0) +: DATA_W] <=
        DATA_W'(pick(rxsrc_q, map_out_q[2*out_slot_q +: 2]));
      fso_q[out_port] <= (out_slot_q == 2'h0) ~^ port_q[iqcfg_pkg::PORT_FS + out_port];
    end
  end
  assign sample_bus_out = out_q;
  assign sample_bus_oe = oe_q;
  assign frame_sync_out = fso_q;

  // Read-back mux, loaded every cycle from the current address
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rdata_q <= 32'h0000_0000;
    else begin
      case (avs_address)
        iqcfg_pkg::REG_CTRL: rdata_q <= ctrl_q;
        iqcfg_pkg::REG_RESET: rdata_q <= reset_q;
        iqcfg_pkg::REG_PORT: rdata_q <= port_q;
        iqcfg_pkg::REG_MAP_OUT: rdata_q <= map_out_q;
        iqcfg_pkg::REG_MAP_IN: rdata_q <= map_in_q;
        iqcfg_pkg::REG_CLKSEL: rdata_q <= clksel_q;
        iqcfg_pkg::REG_PAD: rdata_q <= pad_q;
        iqcfg_pkg::REG_STATUS: rdata_q <= {24'h0, oe_q, out_slot_q, in_slot_q, tx_v_q, 1'b0};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end
  assign avs_readdata = rdata_q;
endmodule

// >>> iqcfg_sva.sv
// Checker for the IQ sample port block, bound to iqcfg_top.
// Assumes one clock domain with an active-low asynchronous reset.
`timescale 1ns/1ns
module iqcfg_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register bus
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Sample stream and configuration
  input wire logic tx_samples_valid,
  input wire logic [3:0] chan_enable,
  input wire logic [17:0] pad_pullup,
  input wire logic [4:0] pad_drive_high
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Bus handshake: one wait cycle, then the answer
  property p_wait_first; $rose(avs_read || avs_write) |-> avs_waitrequest; endproperty
  a_wait_first: assert property (p_wait_first) else $error("no wait in first cycle");
  property p_wait_end; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_wait_end: assert property (p_wait_end) else $error("wait longer than one cycle");
  property p_rd_hole;
    avs_read && !avs_waitrequest && avs_address == 8'h20 |-> avs_readdata == 32'h0;
  endproperty
  a_rd_hole: assert property (p_rd_hole) else $error("unmapped read not zero");
  // Enables: reserved bits, reset state, change only by a write; pad reset state
  property p_rd_ctrl;
    avs_read && !avs_waitrequest && avs_address == 8'h00 |-> avs_readdata[31:5] == 27'h0;
  endproperty
  a_rd_ctrl: assert property (p_rd_ctrl) else $error("reserved enable bits set");
  property p_rst_en; $rose(rst_n) |-> chan_enable == 4'hf; endproperty
  a_rst_en: assert property (p_rst_en) else $error("channels off after reset");
  property p_en_cause;
    $changed(chan_enable) |-> $past(avs_write && !avs_waitrequest && avs_address == 8'h00);
  endproperty
  a_en_cause: assert property (p_en_cause) else $error("enables moved alone");
  property p_rst_pad; $rose(rst_n) |-> &pad_pullup && pad_drive_high == 5'h0; endproperty
  a_rst_pad: assert property (p_rst_pad) else $error("pad reset state");
  // A frame of four link words gives one short pulse
  property p_valid_once; tx_samples_valid |=> !tx_samples_valid [*8]; endproperty
  a_valid_once: assert property (p_valid_once) else $error("frame pulse too close");
  c_read: cover property (avs_read && !avs_waitrequest);
  c_write: cover property (avs_write && !avs_waitrequest);
  c_frame: cover property (tx_samples_valid);
endmodule
bind iqcfg_top iqcfg_sva u_sva (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .tx_samples_valid(tx_samples_valid),
  .chan_enable(chan_enable), .pad_pullup(pad_pullup), .pad_drive_high(pad_drive_high));

// >>> iqcfg_bb_model.sv
// Baseband-side model of the two sample ports.
// Assumes port 1 sends samples out and port 2 takes them in.
`timescale 1ns/1ns
module iqcfg_bb_model (
  // Link clocks and frame-sync pins
  output logic fast_clock_in_1,
  output logic fast_clock_in_2,
  output logic [1:0] frame_sync_in,
  // Sample buses
  output logic [31:0] sample_bus_in,
  input wire logic [31:0] sample_bus_out,
  input wire logic [1:0] sample_bus_oe,
  input wire logic [1:0] frame_sync_out
);
  logic [15:0] drv_q = 16'h0f0f;
  logic fs_q = 1'b1;
  logic [15:0] cap_word[8];
  logic cap_fs[8];
  // Pull-ups hold undriven lines high
  assign sample_bus_in[15:0] = sample_bus_oe[0] ? sample_bus_out[15:0] : 16'hffff;
  assign sample_bus_in[31:16] = sample_bus_oe[1] ? sample_bus_out[31:16] : drv_q;
  assign frame_sync_in = {fs_q, 1'b1};
  initial begin
    fast_clock_in_1 = 1'b0;
    fast_clock_in_2 = 1'b0;
  end
  // Nine link periods, last four carry the frame; clocks stop after
  task automatic run_frame(input logic fs, input logic [3:0][15:0] w);
    for (int i = 0; i < 9; i++) begin
      drv_q = (i > 4) ? w[8-i] : ~drv_q;
      fs_q = (i == 5) ? fs : !fs;
      #200;
      if (i > 0) begin
        cap_word[i-1] = sample_bus_in[15:0];
        cap_fs[i-1] = frame_sync_out[0];
      end
      fast_clock_in_1 = 1'b1;
      fast_clock_in_2 = 1'b1;
      #200;
      fast_clock_in_1 = 1'b0;
      fast_clock_in_2 = 1'b0;
    end
    drv_q = ~drv_q;
  endtask
endmodule

// >>> iq_sample_port_config_bench.sv
// Bench for the IQ sample port block: bus tasks, register and frame tests.
// Assumes the baseband model and the bound checker.
`timescale 1ns/1ns
module iq_sample_port_config_bench;
  logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wq = 1'b0, wt, f1, f2, tv;
  logic [7:0] adr = 8'h0;
  logic [31:0] wd = 32'h0, rdata, rdat, bin_w, bout_w;
  logic [3:0] be = 4'hf, en, lr;
  logic [1:0] fsi, fso, oe, trd, twr, rrd;
  logic [17:0] pu;
  logic [4:0] dh;
  iqcfg_pkg::iqcfg_samples_t prc = 64'h1111_2222_3333_4444, txs, rxf, last;
  logic [7:0] ra[8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h20};
  logic [31:0] rv[8] = '{32'h1f, 32'h0, 32'h1130, 32'he4e4, 32'he4e4, 32'h10, 32'h3ffff, 32'h0};
  int error_cnt = 0, n_compared = 0;
  // Bus clock
  always #25 clk = ~clk;
  // Latest sample set from the incoming port
  always @(posedge clk) begin
    if (tv === 1'b1)
      last <= txs;
  end
  iqcfg_top dut (.clk(clk), .rst_n(rst_n), .avs_address(adr), .avs_read(rd), .avs_write(wq),
    .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(wt),
    .fast_clock_in_1(f1), .fast_clock_in_2(f2), .frame_sync_in(fsi), .sample_bus_in(bin_w),
    .sample_bus_out(bout_w), .sample_bus_oe(oe), .frame_sync_out(fso), .rx_proc_samples(prc),
    .tx_samples(txs), .tx_samples_valid(tv), .rx_fifo_samples(rxf), .chan_enable(en),
    .chan_logic_reset(lr), .tx_read_clk_sel(trd), .tx_write_clk_sel(twr),
    .rx_read_clk_sel(rrd), .pad_pullup(pu), .pad_drive_high(dh));
  iqcfg_bb_model bb (.fast_clock_in_1(f1), .fast_clock_in_2(f2), .frame_sync_in(fsi),
    .sample_bus_in(bin_w), .sample_bus_out(bout_w), .sample_bus_oe(oe), .frame_sync_out(fso));
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // One transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] b);
    int n;
    n = 0;
    @(posedge clk);
    {rd, wq, adr, wd, be} <= {!w, w, a, d, b};
    do begin
      @(posedge clk);
      n++;
    end while (n < 20 && wt !== 1'b0);
    if (n == 20 && wt !== 1'b0) begin
      error_cnt++;
      finish_test();
    end
    rdat = rdata;
    {rd, wq} <= 2'b00;
  endtask
  // One frame each way; the outgoing frame is found by its sync level
  task automatic frame(input logic fs, input logic [63:0] w, input logic [63:0] exp);
    int k;
    k = 1;
    bb.run_frame(fs, w);
    repeat (8) @(negedge clk);
    check("frame in", last, exp);
    while (k < 4 && bb.cap_fs[k] !== fs)
      k++;
    check("frame out", {bb.cap_word[k], bb.cap_word[k+1], bb.cap_word[k+2],
      bb.cap_word[k+3]}, prc);
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check("enables", en, 4'hf);
    check("logic resets", lr, 4'h0);
    check("pads", {dh, pu}, 23'h3ffff);
    check("clock selects", {rrd, twr, trd}, 6'h10);
    bus(1'b1, 8'h20, 32'hffff_ffff, 4'hf);
    foreach (ra[i]) begin
      bus(1'b0, ra[i], 32'h0, 4'hf);
      check("register", rdat, rv[i]);
    end
    bus(1'b1, 8'h00, 32'h0a, 4'hf);
    repeat (2) @(negedge clk);
    check("enables", en, 4'ha);
    bus(1'b1, 8'h00, 32'h1f, 4'hf);
    bus(1'b1, 8'h04, 32'h305, 4'hf);
    repeat (2) @(negedge clk);
    check("logic resets", lr, 4'h5);
    check("rx fifo", rxf, 64'h0);
    check("tx fifo", txs, 64'h0);
    bus(1'b1, 8'h08, 32'h2133, 4'hf);
    bus(1'b1, 8'h0c, 32'h1b1b, 4'hf);
    bus(1'b1, 8'h04, 32'h3f0, 4'hf);
    bus(1'b0, 8'h08, 32'h0, 4'hf);
    check("port restored", rdat, 32'h1130);
    bus(1'b0, 8'h0c, 32'h0, 4'hf);
    check("map restored", rdat, 32'he4e4);
    bus(1'b1, 8'h04, 32'h0, 4'hf);
    bus(1'b1, 8'h18, 32'h0, 4'h1);
    bus(1'b1, 8'h18, 32'h0040_0000, 4'h4);
    @(negedge clk);
    check("pads", {dh, pu}, 23'h40ff00);
    bus(1'b1, 8'h18, 32'h3ffff, 4'hf);
    bus(1'b1, 8'h14, 32'h39, 4'hf);
    @(negedge clk);
    check("clock selects", {rrd, twr, trd}, 6'h39);
    bus(1'b1, 8'h14, 32'h10, 4'hf);
    repeat (4) @(negedge clk);
    check("rx source", rxf, prc);
    frame(1'b0, 64'ha0a0_a1a1_a2a2_a3a3, 64'ha0a0_a1a1_a2a2_a3a3);
    check("port drive", oe, 2'b01);
    bus(1'b1, 8'h00, 32'h0a, 4'hf);
    bb.run_frame(1'b0, 64'h0);
    check("port drive", oe, 2'b00);
    bus(1'b1, 8'h00, 32'h1f, 4'hf);
    bus(1'b1, 8'h04, 32'h300, 4'hf);
    bus(1'b1, 8'h08, 32'h1133, 4'hf);
    bus(1'b1, 8'h10, 32'h1b1b, 4'hf);
    bus(1'b1, 8'h04, 32'h0, 4'hf);
    frame(1'b1, 64'h5050_6161_7272_8383, 64'h8383_7272_6161_5050);
    finish_test();
  end
endmodule
